// [hw/txrs_defines.vh]
`ifndef TXRS_DEFINES_VH
`define TXRS_DEFINES_VH

// register offsets
`define TXRS_OFS_OP_SELECT 7'h1f
`define TXRS_OFS_SOURCE_CHOICE 7'h20
`define TXRS_OFS_FAULT_MASKS 7'h21
`define TXRS_OFS_RESTORE_DELAY 7'h22
`define TXRS_OFS_REVERT_ENABLES 7'h23
`define TXRS_OFS_RANK_0 7'h24
`define TXRS_OFS_RANK_1 7'h25
`define TXRS_OFS_RANK_2 7'h26

// reset values
`define TXRS_RST_SOURCE_CHOICE 4'h0
`define TXRS_RST_FAULT_MASKS 8'h3c
`define TXRS_RST_REVERT_ENABLES 5'h00
`define TXRS_RST_RESTORE_DELAY 4'h0
`define TXRS_RST_RANK_0 8'h10
`define TXRS_RST_RANK_1 8'h32
`define TXRS_RST_RANK_2 8'h54

// field positions
`define TXRS_MODE_MSB 2
`define TXRS_SW_MASK_LSB 0
`define TXRS_HO_MASK_LSB 4

// operating mode codes
`define TXRS_MODE_MAN_NORMAL 3'b000
`define TXRS_MODE_MAN_HOLDOVER 3'b001
`define TXRS_MODE_MAN_FREERUN 3'b010
`define TXRS_MODE_AUTO_NORMAL 3'b011
`define TXRS_MODE_PACKET_CLIENT 3'b100

// loop state codes shown on loop_state_o
`define TXRS_ST_TRACK 2'b00
`define TXRS_ST_HOLDOVER 2'b01
`define TXRS_ST_FREERUN 2'b10
`define TXRS_ST_EXT_DCO 2'b11

// source codes
`define TXRS_REF_COUNT 5
`define TXRS_REF_LAST 4'h4
`define TXRS_RANK_EXCLUDED 4'hf

// timing
`define TXRS_CLK_HZ 10000000
`define TXRS_MINUTE_S 60
// one minute of the 10 MHz clock, sized to the 30-bit minute counter
`define TXRS_MINUTE_CYCLES 30'h23c3_4600

`endif

// [hw/txrs_restore_timer.v]
`timescale 1ns/1ns
// holds one reference out of selection until it has been clean long enough
module txrs_restore_timer #(
    parameter [29:0] MINUTE_CYCLES = 30'd600000000
) (
    // clock and reset
    input wire mclk_i,
    input wire sys_rst_i,
    // fault and programmed delay
    input wire fault_i,
    input wire [3:0] delay_min_i,
    // availability
    output reg avail_o
);

reg [29:0] cyc_q;
reg [3:0] min_q;

// any fault restarts the whole wait, so the clean time is continuous
always @(posedge mclk_i)
begin
    if (sys_rst_i)
    begin
        avail_o <= 1'b1;
        cyc_q <= 30'h0000_0000;
        min_q <= 4'h0;
    end
    else if (fault_i)
    begin
        avail_o <= 1'b0;
        cyc_q <= 30'h0000_0000;
        min_q <= 4'h0;
    end
    else if (!avail_o)
    begin
        if (min_q >= delay_min_i)
            avail_o <= 1'b1;
        else if (cyc_q == MINUTE_CYCLES - 30'd1)
        begin
            cyc_q <= 30'h0000_0000;
            min_q <= min_q + 4'h1;
        end
        else
            cyc_q <= cyc_q + 30'd1;
    end
end

endmodule // txrs_restore_timer

// [hw/txrs_ref_select.v]
`timescale 1ns/1ns
`include "txrs_defines.vh"
// How it works
// - mode 000: manual normal, source-choice reference
// - manual reference failed: enter holdover
// - mode 001: stay in holdover
// - mode 010: stay in free-run
// - mode 011: track best-ranked qualified reference
// - tracked reference fails: switch to next best
// - no qualified reference left: holdover
// - mode 100: oscillator steered by external software
// - mode reset value follows mode-select pin
// - source-choice reads tracked ref in auto, writable manual
// - codes 0 to 4 name references; rest reserved
// - switchover fault enables, bits 3:0
// - holdover fault enables, bits 7:4
// - failed reference waits restore minutes before reuse
// - 4-bit rank per reference, 1111 excludes
// - per-reference revertive switching enable
module txrs_ref_select #(
    parameter [29:0] MINUTE_CYCLES = `TXRS_MINUTE_CYCLES,
    parameter [2:0] MODE_PIN_LOW = `TXRS_MODE_AUTO_NORMAL,
    parameter [2:0] MODE_PIN_HIGH = `TXRS_MODE_MAN_FREERUN
) (
    // clock and reset
    input wire mclk_i,
    input wire sys_rst_i,
    // mode-select pin
    input wire mode_pin_i,
    // register port
    input wire [6:0] reg_addr_i,
    input wire [7:0] reg_wdata_i,
    input wire reg_wr_i,
    output reg [7:0] reg_rdata_o,
    // per-reference fault indicators from the monitors
    input wire [4:0] short_cycle_fault_i,
    input wire [4:0] coarse_frequency_fault_i,
    input wire [4:0] guard_soak_fault_i,
    input wire [4:0] precise_frequency_fault_i,
    // loop control
    output reg [1:0] loop_state_o,
    output reg [3:0] tracked_ref_o,
    output reg switchover_o,
    output wire digital_steered_oscillator_ext_o,
    output wire [4:0] ref_qualified_o
);

// gate one reference's four indicators with a four-bit enable field
function masked_fault;
    input [3:0] ind;
    input [3:0] en;
    begin
        masked_fault = |(ind & en);
    end
endfunction

// rank nibble of a reference out of the three rank registers
function [3:0] rank_of;
    input [2:0] idx;
    input [23:0] ranks;
    begin
        case (idx)
            3'd0: rank_of = ranks[3:0];
            3'd1: rank_of = ranks[7:4];
            3'd2: rank_of = ranks[11:8];
            3'd3: rank_of = ranks[15:12];
            3'd4: rank_of = ranks[19:16];
            default: rank_of = `TXRS_RANK_EXCLUDED;
        endcase
    end
endfunction

// codes above the last reference are reserved and never name a source
function ref_legal;
    input [3:0] code;
    begin
        ref_legal = (code <= `TXRS_REF_LAST);
    end
endfunction

reg [2:0] mode_q;
reg [3:0] source_q;
reg [7:0] fault_masks_q;
reg [4:0] revert_q;
reg [3:0] restore_q;
reg [7:0] rank0_q;
reg [7:0] rank1_q;
reg [7:0] rank2_q;
reg [2:0] pin_sync_q;
reg [1:0] state_d;
reg [3:0] track_d;
reg switch_d;
reg pin_level_q;
reg auto_valid_q;

// the three rank registers seen as one vector, ref0 in the lowest nibble
wire [23:0] ranks = {rank2_q, rank1_q, rank0_q};
wire [4:0] sw_fault;
wire [4:0] ho_fault;
wire [4:0] avail;
wire [4:0] qual;

// pin sampled by three flops; level accepted once the last two agree
// the chain has no reset, so reset must last five edges for the settled level to reach the mode
always @(posedge mclk_i)
begin
    pin_sync_q <= {pin_sync_q[1:0], mode_pin_i};
    if (pin_sync_q[2] == pin_sync_q[1])
        pin_level_q <= pin_sync_q[2];
end

// per-reference fault gating and restore timing
genvar gi;
generate
    for (gi = 0; gi < `TXRS_REF_COUNT; gi = gi + 1)
    begin : g_ref
        wire [3:0] ind = {precise_frequency_fault_i[gi], guard_soak_fault_i[gi],
            coarse_frequency_fault_i[gi], short_cycle_fault_i[gi]};
        assign sw_fault[gi] = masked_fault(ind, fault_masks_q[3:0]);
        assign ho_fault[gi] = masked_fault(ind, fault_masks_q[7:4]);
        txrs_restore_timer #(
            .MINUTE_CYCLES(MINUTE_CYCLES)
        ) u_timer (
            .mclk_i(mclk_i),
            .sys_rst_i(sys_rst_i),
            .fault_i(sw_fault[gi] | ho_fault[gi]),
            .delay_min_i(restore_q),
            .avail_o(avail[gi])
        );
        // excluded rank never counts as a candidate
        assign qual[gi] = avail[gi] & ~sw_fault[gi]
            & (ranks[4*gi +: 4] != `TXRS_RANK_EXCLUDED);
    end
endgenerate

assign ref_qualified_o = qual;

// best-ranked qualified reference; on equal rank the lower index wins
// a plain scan over five sources is cheap and keeps ties deterministic
reg [2:0] best_idx;
reg best_ok;
integer k;
always @*
begin
    best_idx = 3'd0;
    best_ok = 1'b0;
    for (k = 0; k < `TXRS_REF_COUNT; k = k + 1)
    begin
        if (qual[k] && (!best_ok || rank_of(k[2:0], ranks) < rank_of(best_idx, ranks)))
        begin
            best_idx = k[2:0];
            best_ok = 1'b1;
        end
    end
end

wire [2:0] cur_idx = tracked_ref_o[2:0];
// reserved codes are screened before they can index a reference
wire cur_legal = ref_legal(tracked_ref_o);
wire cur_qual = auto_valid_q && cur_legal && qual[cur_idx];
wire src_legal = ref_legal(source_q);
wire [2:0] src_idx = source_q[2:0];
wire best_better = rank_of(best_idx, ranks) < rank_of(cur_idx, ranks);

// loop state and tracked reference for the next cycle
always @*
begin
    state_d = `TXRS_ST_HOLDOVER;
    track_d = tracked_ref_o;
    switch_d = 1'b0;
    case (mode_q)
        `TXRS_MODE_MAN_NORMAL:
        begin
            track_d = source_q;
            // reserved codes have no reference behind them, so hold over
            if (!src_legal || sw_fault[src_idx] || ho_fault[src_idx] || !avail[src_idx])
                state_d = `TXRS_ST_HOLDOVER;
            else
                state_d = `TXRS_ST_TRACK;
            switch_d = (source_q != tracked_ref_o);
        end
        `TXRS_MODE_MAN_HOLDOVER:
            state_d = `TXRS_ST_HOLDOVER;
        `TXRS_MODE_MAN_FREERUN:
            state_d = `TXRS_ST_FREERUN;
        `TXRS_MODE_AUTO_NORMAL:
        begin
            if (!cur_qual)
            begin
                if (best_ok)
                begin
                    track_d = {1'b0, best_idx};
                    switch_d = ({1'b0, best_idx} != tracked_ref_o);
                    state_d = `TXRS_ST_TRACK;
                end
                else
                    state_d = `TXRS_ST_HOLDOVER;
            end
            else if (best_ok && best_better && revert_q[best_idx])
            begin
                track_d = {1'b0, best_idx};
                switch_d = 1'b1;
                state_d = `TXRS_ST_TRACK;
            end
            else if (ho_fault[cur_idx])
                state_d = `TXRS_ST_HOLDOVER;
            else
                state_d = `TXRS_ST_TRACK;
        end
        `TXRS_MODE_PACKET_CLIENT:
            state_d = `TXRS_ST_EXT_DCO;
        default:
            state_d = `TXRS_ST_HOLDOVER;
    endcase
end

// loop control registers
always @(posedge mclk_i)
begin
    if (sys_rst_i)
    begin
        // holdover at reset: no source has been qualified yet
        loop_state_o <= `TXRS_ST_HOLDOVER;
        tracked_ref_o <= `TXRS_RST_SOURCE_CHOICE;
        switchover_o <= 1'b0;
        auto_valid_q <= 1'b0;
    end
    else
    begin
        loop_state_o <= state_d;
        tracked_ref_o <= track_d;
        switchover_o <= switch_d && (state_d == `TXRS_ST_TRACK);
        // entering auto mode forces a fresh pick rather than a stale one
        auto_valid_q <= (mode_q == `TXRS_MODE_AUTO_NORMAL) && (state_d == `TXRS_ST_TRACK);
    end
end

assign digital_steered_oscillator_ext_o = (mode_q == `TXRS_MODE_PACKET_CLIENT);

// in auto mode the selector owns the source-choice register
wire auto_mode = (mode_q == `TXRS_MODE_AUTO_NORMAL);

// register writes; mode reset follows the settled pin while reset is held
always @(posedge mclk_i)
begin
    if (sys_rst_i)
    begin
        mode_q <= pin_level_q ? MODE_PIN_HIGH : MODE_PIN_LOW;
        source_q <= `TXRS_RST_SOURCE_CHOICE;
        fault_masks_q <= `TXRS_RST_FAULT_MASKS;
        revert_q <= `TXRS_RST_REVERT_ENABLES;
        restore_q <= `TXRS_RST_RESTORE_DELAY;
        rank0_q <= `TXRS_RST_RANK_0;
        rank1_q <= `TXRS_RST_RANK_1;
        rank2_q <= `TXRS_RST_RANK_2;
    end
    else if (reg_wr_i)
    begin
        case (reg_addr_i)
            // upper bits are expected zero and are not stored
            `TXRS_OFS_OP_SELECT: mode_q <= reg_wdata_i[`TXRS_MODE_MSB:0];
            `TXRS_OFS_SOURCE_CHOICE:
                if (!auto_mode)
                    source_q <= reg_wdata_i[3:0];
            `TXRS_OFS_FAULT_MASKS: fault_masks_q <= reg_wdata_i;
            `TXRS_OFS_RESTORE_DELAY: restore_q <= reg_wdata_i[3:0];
            `TXRS_OFS_REVERT_ENABLES: revert_q <= reg_wdata_i[4:0];
            `TXRS_OFS_RANK_0: rank0_q <= reg_wdata_i;
            `TXRS_OFS_RANK_1: rank1_q <= reg_wdata_i;
            `TXRS_OFS_RANK_2: rank2_q <= reg_wdata_i;
            default: ;
        endcase
    end
    // mirror only while tracking, so holdover keeps the last source shown
    else if (auto_mode && loop_state_o == `TXRS_ST_TRACK)
        source_q <= tracked_ref_o;
end

// read data registered one cycle after the address; unmapped reads zero
always @(posedge mclk_i)
begin
    if (sys_rst_i)
        reg_rdata_o <= 8'h00;
    else
    begin
        // unused upper bits are padded with zeros, never stored
        case (reg_addr_i)
            `TXRS_OFS_OP_SELECT: reg_rdata_o <= {5'h00, mode_q};
            `TXRS_OFS_SOURCE_CHOICE: reg_rdata_o <= {4'h0, source_q};
            `TXRS_OFS_FAULT_MASKS: reg_rdata_o <= fault_masks_q;
            `TXRS_OFS_RESTORE_DELAY: reg_rdata_o <= {4'h0, restore_q};
            `TXRS_OFS_REVERT_ENABLES: reg_rdata_o <= {3'h0, revert_q};
            `TXRS_OFS_RANK_0: reg_rdata_o <= rank0_q;
            `TXRS_OFS_RANK_1: reg_rdata_o <= rank1_q;
            `TXRS_OFS_RANK_2: reg_rdata_o <= rank2_q;
            default: reg_rdata_o <= 8'h00;
        endcase
    end
end

endmodule // txrs_ref_select

// [verif/txrs_ref_mon.sv]
`timescale 1ns/1ns
// five reference monitors; bit kind*5+ref, kinds scm, cfm, gst, pfm
module txrs_ref_mon (
    // clock
    input wire mclk_i,
    // fault levels
    output logic [19:0] fault_o
);
    initial fault_o = '0;
    // flags move just after an edge so the design never races them
    task automatic put(input logic [19:0] v);
        @(posedge mclk_i);
        #5 fault_o = v;
    endtask
endmodule // txrs_ref_mon

// [verif/txrs_ref_select_checker.sv]
`timescale 1ns/1ns
module txrs_chk (
    // clock, reset, pin, register port
    input wire mclk_i,
    input wire sys_rst_i,
    input wire mode_pin_i,
    input wire [6:0] reg_addr_i,
    input wire [7:0] reg_wdata_i,
    input wire reg_wr_i,
    // monitor faults
    input wire [4:0] short_cycle_fault_i,
    input wire [4:0] coarse_frequency_fault_i,
    input wire [4:0] guard_soak_fault_i,
    input wire [4:0] precise_frequency_fault_i,
    // loop control
    input wire [1:0] loop_state_o,
    input wire [3:0] tracked_ref_o,
    input wire switchover_o,
    input wire digital_steered_oscillator_ext_o,
    input wire [4:0] ref_qualified_o
);
    logic [2:0] md_q;
    logic [7:0] mk_q;
    logic rd_q;
    logic [4:0] swf;
    logic [4:0] hof;
    default clocking @(posedge mclk_i); endclocking
    default disable iff (sys_rst_i);
    // shadow mode and masks; first edge after reset is skipped, outputs still settle
    always @(posedge mclk_i)
    begin
        rd_q <= sys_rst_i;
        if (sys_rst_i)
        begin
            md_q <= mode_pin_i ? 3'h2 : 3'h3;
            mk_q <= 8'h3c;
        end
        else if (reg_wr_i && reg_addr_i == 7'h1f)
            md_q <= reg_wdata_i[2:0];
        else if (reg_wr_i && reg_addr_i == 7'h21)
            mk_q <= reg_wdata_i;
    end
    // faults left after each mask set
    assign swf = {5{mk_q[0]}} & short_cycle_fault_i | {5{mk_q[1]}} & coarse_frequency_fault_i
        | {5{mk_q[2]}} & guard_soak_fault_i | {5{mk_q[3]}} & precise_frequency_fault_i;
    assign hof = {5{mk_q[4]}} & short_cycle_fault_i | {5{mk_q[5]}} & coarse_frequency_fault_i
        | {5{mk_q[6]}} & guard_soak_fault_i | {5{mk_q[7]}} & precise_frequency_fault_i;
    sequence s_moved;
        tracked_ref_o != $past(tracked_ref_o) && loop_state_o == 2'h0;
    endsequence
    property p_hold;
        !rd_q && md_q == 3'h1 |=> loop_state_o == 2'h1;
    endproperty
    a_hold: assert property (p_hold) else $error("holdover mode left");
    property p_free;
        !rd_q && md_q == 3'h2 |=> loop_state_o == 2'h2;
    endproperty
    a_free: assert property (p_free) else $error("free-run mode left");
    property p_ext;
        digital_steered_oscillator_ext_o == (md_q == 3'h4);
    endproperty
    a_ext: assert property (p_ext) else $error("oscillator handover wrong");
    property p_swmask;
        (swf & ref_qualified_o) == 5'h0;
    endproperty
    a_swmask: assert property (p_swmask) else $error("faulty source qualified");
    property p_hoqual;
        |hof |=> ($past(hof) & ref_qualified_o) == 5'h0;
    endproperty
    a_hoqual: assert property (p_hoqual) else $error("holdover fault ignored");
    property p_switch;
        switchover_o |-> s_moved;
    endproperty
    a_switch: assert property (p_switch) else $error("switch pulse wrong");
    property p_moved;
        s_moved |-> switchover_o;
    endproperty
    a_moved: assert property (p_moved) else $error("source moved without pulse");
    property p_auto;
        !rd_q && md_q == 3'h3 && |ref_qualified_o && hof == 5'h0 |=> loop_state_o == 2'h0
            && (($past(ref_qualified_o) >> tracked_ref_o) & 5'h1) != 5'h0;
    endproperty
    a_auto: assert property (p_auto) else $error("auto tracks unqualified");
    property p_none;
        !rd_q && md_q == 3'h3 && ref_qualified_o == 5'h0 |=> loop_state_o == 2'h1;
    endproperty
    a_none: assert property (p_none) else $error("no holdover without source");
endmodule // txrs_chk

// [verif/txrs_ref_select_tb.sv]
`timescale 1ns/1ns
module txrs_ref_select_tb;
    logic mclk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic mode_pin_i = 1'b0;
    logic [6:0] reg_addr_i = 7'h00;
    logic [7:0] reg_wdata_i = 8'h00;
    logic reg_wr_i = 1'b0;
    wire [7:0] reg_rdata_o;
    wire [19:0] flt;
    wire [1:0] loop_state_o;
    wire [3:0] tracked_ref_o;
    wire switchover_o;
    wire ext_o;
    wire [4:0] ref_qualified_o;
    int miscompares = 0;
    int checks = 0;
    int seed = 71;
    int rk[5];
    logic [31:0] r;
    logic [19:0] v;
    logic [4:0] ok;
    logic [6:0] ra[9] = '{7'h1f, 7'h20, 7'h21, 7'h22, 7'h23, 7'h24, 7'h25, 7'h26, 7'h10};
    logic [7:0] rv[9] = '{8'h03, 8'h00, 8'h3c, 8'h00, 8'h00, 8'h10, 8'h32, 8'h54, 8'h00};
    logic [7:0] st[8] = '{8'h00, 8'h01, 8'h02, 8'h00, 8'h03, 8'h01, 8'h01, 8'h01};
    // one minute shortened to ten cycles
    txrs_ref_select #(.MINUTE_CYCLES(30'd10)) txrs_ref_select_i (
        .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .mode_pin_i(mode_pin_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
        .reg_rdata_o(reg_rdata_o),
        .short_cycle_fault_i(flt[4:0]), .coarse_frequency_fault_i(flt[9:5]),
        .guard_soak_fault_i(flt[14:10]), .precise_frequency_fault_i(flt[19:15]),
        .loop_state_o(loop_state_o), .tracked_ref_o(tracked_ref_o),
        .switchover_o(switchover_o),
        .digital_steered_oscillator_ext_o(ext_o), .ref_qualified_o(ref_qualified_o));
    txrs_ref_mon txrs_ref_mon_i (.mclk_i(mclk_i), .fault_o(flt));
    // clock and watchdog
    initial forever #50 mclk_i = ~mclk_i;
    initial
    begin
        #400000;
        miscompares++;
        summarize;
    end
    task automatic cmp(input logic [7:0] seen, input logic [7:0] exp, input string what);
        checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge mclk_i);
        #5;
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        reg_addr_i = a;
        reg_wdata_i = d;
        reg_wr_i = 1'b1;
        tick(1);
        reg_wr_i = 1'b0;
        // idle edge so a following write never re-raises the strobe at once
        tick(1);
    endtask
    task automatic rd(input logic [6:0] a, input logic [7:0] e);
        reg_addr_i = a;
        tick(1);
        cmp(reg_rdata_o, e, "reg");
    endtask
    // pin must settle through its synchroniser, so reset outlasts it
    task automatic rst(input logic pin);
        mode_pin_i = pin;
        sys_rst_i = 1'b1;
        tick(5);
        sys_rst_i = 1'b0;
        tick(2);
    endtask
    // best rank wins, ties to the lower index
    function automatic int best(input logic [4:0] q);
        int b;
        b = -1;
        for (int n = 0; n < 5; n++)
            if (q[n] && (b < 0 || rk[n] < rk[b]))
                b = n;
        return b;
    endfunction
    task automatic summarize;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial
    begin
        rst(1'b1);
        rd(7'h1f, 8'h02);
        rst(1'b0);
        for (int i = 0; i < 9; i++)
            rd(ra[i], rv[i]);
        $display("reset test done");
        for (int m = 0; m < 8; m++)
        begin
            wr(7'h1f, 8'(m));
            tick(1);
            cmp(loop_state_o, st[m], "state");
            cmp(ext_o, m == 4, "ext");
        end
        wr(7'h1f, 8'h00);
        wr(7'h20, 8'h02);
        tick(1);
        cmp(tracked_ref_o, 8'h02, "ref");
        txrs_ref_mon_i.put(20'h0_1000);
        tick(1);
        cmp(loop_state_o, 8'h01, "state");
        txrs_ref_mon_i.put('0);
        tick(3);
        cmp(loop_state_o, 8'h00, "state");
        wr(7'h20, 8'h05);
        cmp(loop_state_o, 8'h01, "state");
        $display("mode test done");
        wr(7'h22, 8'h01);
        wr(7'h23, 8'h01);
        wr(7'h1f, 8'h03);
        tick(1);
        cmp(tracked_ref_o, 8'h00, "ref");
        txrs_ref_mon_i.put(20'h0_8000);
        tick(1);
        cmp(tracked_ref_o, 8'h01, "ref");
        cmp(switchover_o, 8'h01, "switch");
        wr(7'h20, 8'h04);
        rd(7'h20, 8'h01);
        txrs_ref_mon_i.put('0);
        tick(5);
        cmp(tracked_ref_o, 8'h01, "ref");
        tick(12);
        cmp(tracked_ref_o, 8'h00, "ref");
        wr(7'h21, 8'h10);
        txrs_ref_mon_i.put(20'h0_0001);
        tick(1);
        cmp(loop_state_o, 8'h01, "state");
        $display("auto test done");
        wr(7'h21, 8'h0f);
        wr(7'h22, 8'h00);
        wr(7'h23, 8'h1f);
        for (int i = 0; i < 40; i++)
        begin
            r = $random(seed);
            wr(7'h24, r[7:0]);
            wr(7'h25, r[15:8]);
            wr(7'h26, {4'h0, r[19:16]});
            v = $random(seed) & $random(seed) & $random(seed);
            txrs_ref_mon_i.put(v);
            tick(3);
            for (int n = 0; n < 5; n++)
            begin
                rk[n] = r[4*n +: 4];
                ok[n] = !(v[n] | v[n+5] | v[n+10] | v[n+15]) && rk[n] != 15;
            end
            cmp(ref_qualified_o, ok, "qual");
            cmp(loop_state_o, ok == 0 ? 8'h01 : 8'h00, "state");
            // equal ranks may keep the current source, so the rank is what counts
            if (ok != 0)
            begin
                cmp(8'(rk[tracked_ref_o[2:0]]), 8'(rk[best(ok)]), "rank");
                cmp(8'(ok[tracked_ref_o[2:0]]), 8'h01, "ref");
            end
        end
        $display("random test done");
        summarize;
    end
endmodule // txrs_ref_select_tb
bind txrs_ref_select txrs_chk txrs_chk_i (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
    .mode_pin_i(mode_pin_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .short_cycle_fault_i(short_cycle_fault_i),
    .coarse_frequency_fault_i(coarse_frequency_fault_i),
    .guard_soak_fault_i(guard_soak_fault_i),
    .precise_frequency_fault_i(precise_frequency_fault_i), .loop_state_o(loop_state_o),
    .tracked_ref_o(tracked_ref_o), .switchover_o(switchover_o),
    .digital_steered_oscillator_ext_o(digital_steered_oscillator_ext_o),
    .ref_qualified_o(ref_qualified_o));
